/* pkg/rdcs_pkg.sv */
package rdcs_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ              = 200;
    localparam int POWER_ON_DELAY_US    = 10;
    localparam int STARTUP_DELAY_US     = 20;
    localparam int POWER_UP_TIMER_MS    = 64;
    localparam int RESET_TIME_US        = 20;
    localparam int PLL_LOCK_TIME_US     = 20;
    localparam int MONITOR_DELAY_US     = 500;
    localparam int POWER_ON_CYC         = POWER_ON_DELAY_US * CLK_MHZ;
    localparam int STARTUP_CYC          = STARTUP_DELAY_US * CLK_MHZ;
    localparam int POWER_UP_TIMER_CYC   = POWER_UP_TIMER_MS * 1000 * CLK_MHZ;
    localparam int RESET_TIME_CYC       = RESET_TIME_US * CLK_MHZ;
    localparam int PLL_LOCK_CYC         = PLL_LOCK_TIME_US * CLK_MHZ;
    localparam int MONITOR_DELAY_CYC    = MONITOR_DELAY_US * CLK_MHZ;
    localparam int OSC_STARTUP_PERIODS  = 1024;
    localparam int OSC_STARTUP_W        = 10;
    localparam int CNT_W                = 24;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_RESET_CTRL = 4'h0;
    localparam logic [3:0] ADDR_OSC_CTRL   = 4'h1;
    localparam logic [3:0] ADDR_STATUS     = 4'h2;
    localparam logic [3:0] ADDR_CONFIG     = 4'h3;

    // reset_control_reg flag positions, then the oscillator control current-select lsb and the status fail-clear bit
    localparam int RF_POWER_ON   = 0;
    localparam int RF_BROWN_OUT  = 1;
    localparam int RF_WATCHDOG   = 4;
    localparam int RF_SOFTWARE   = 6;
    localparam int RF_MASTER_CLR = 7;
    localparam int RF_ILLEGAL    = 14;
    localparam int RF_TRAP_CONF  = 15;
    localparam int OSC_CUR_LSB   = 12;
    localparam int OSC_FAIL_BIT  = 3;
    localparam logic [15:0] RESET_CTRL_RST = 16'h0003;

    // oscillator select codes
    localparam logic [2:0] OSC_FAST_RC   = 3'h0;
    localparam logic [2:0] OSC_FAST_PLL  = 3'h1;
    localparam logic [2:0] OSC_PRI       = 3'h2;
    localparam logic [2:0] OSC_PRI_PLL   = 3'h3;
    localparam logic [2:0] OSC_SEC       = 3'h4;
    localparam logic [2:0] OSC_LOW_RC    = 3'h5;

    localparam logic [23:0] RESET_PC = 24'h000000;

    typedef enum logic [4:0] {
        ST_HOLD    = 5'h01,
        ST_DELAY   = 5'h02,
        ST_CLKWAIT = 5'h04,
        ST_MONWAIT = 5'h08,
        ST_RUN     = 5'h10
    } rdcs_state_e;

    typedef struct packed {
        logic power_on;
        logic brown_out;
        logic master_clr;
        logic watchdog;
        logic software;
        logic illegal;
        logic trap_conf;
    } rdcs_src_s;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } rdcs_bus_s;

endpackage : rdcs_pkg

/* hw/rdcs_timer.sv */
`timescale 1ns/1ps
module rdcs_timer
    import rdcs_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] count,
    input  wire logic             tick,
    output logic                  done
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             done;
    } rdcs_tmr_s;

    rdcs_tmr_s st_ff;
    rdcs_tmr_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (load) begin
            nxt_st.cnt  = count;
            nxt_st.done = (count == '0);
        end else if (tick && !st_ff.done) begin
            nxt_st.cnt  = st_ff.cnt - 1'b1;
            nxt_st.done = (st_ff.cnt == {{(CNT_W-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign done = st_ff.done;
endmodule : rdcs_timer

/* hw/rdcs_sequencer.sv */
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module rdcs_sequencer
    import rdcs_pkg::*;
#(
    parameter int POWER_UP_TIMER_CYCLES = POWER_UP_TIMER_CYC,
    parameter int MONITOR_CYCLES        = MONITOR_DELAY_CYC
)(
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire rdcs_src_s   RESET_SRC,
    input  wire logic        WAKE,
    input  wire logic        REGULATOR_EN,
    input  wire logic        SWITCH_EN,
    input  wire logic        MONITOR_EN,
    input  wire logic [2:0]  INITIAL_OSC_SELECT_BITS,
    input  wire logic        OSC_TICK,
    input  wire logic        PLL_LOCKED,
    input  wire logic        CLOCK_VALID,
    input  wire rdcs_bus_s   BUS,
    output logic [15:0]      RDATA,
    output logic             SYSTEM_RESET_OUT,
    output logic             CLOCK_RELEASE,
    output logic             MONITOR_START,
    output logic             OSC_FAIL_TRAP,
    output logic [2:0]       CLOCK_SELECT,
    output logic [23:0]      PC_RESET
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        rdcs_state_e state;
        logic [15:0] reset_ctrl;
        logic [2:0]  cur_osc;
        logic        clk_done;
        logic        long_path;
        logic        fail;
        logic        sys_rst;
        logic        clk_rel;
        logic        mon;
        logic [15:0] rdata;
        logic [23:0] pc;
    } rdcs_seq_s;

    rdcs_seq_s st_ff;
    rdcs_seq_s nxt_st;

    logic             any_src;
    logic             cold;
    logic             warm;
    logic [2:0]       sel;
    logic             is_pll;
    logic             is_xtal;
    logic             dly_load;
    logic [CNT_W-1:0] dly_cnt;
    logic             dly_done;
    logic             ost_load;
    logic             ost_done;
    logic             lock_load;
    logic             lock_done;
    logic             mon_load;
    logic             mon_done;

    // ------------------------------------------------------------------
    // source decode
    // ------------------------------------------------------------------
    assign any_src = |RESET_SRC;
    assign cold    = RESET_SRC.power_on | RESET_SRC.brown_out;
    assign warm    = RESET_SRC.master_clr | RESET_SRC.watchdog | RESET_SRC.software
                   | RESET_SRC.illegal | RESET_SRC.trap_conf;

    always_comb begin
        if (!SWITCH_EN || cold) begin
            sel = INITIAL_OSC_SELECT_BITS;
        end else begin
            sel = st_ff.cur_osc;
        end
    end

    assign is_pll  = (sel == OSC_FAST_PLL) || (sel == OSC_PRI_PLL);
    assign is_xtal = (sel == OSC_PRI) || (sel == OSC_PRI_PLL) || (sel == OSC_SEC);

    // reset delay length by reset type
    always_comb begin
        dly_cnt = CNT_W'(RESET_TIME_CYC);
        if (cold || WAKE) begin
            if (REGULATOR_EN) begin
                dly_cnt = CNT_W'(STARTUP_CYC + RESET_TIME_CYC);
            end else begin
                dly_cnt = CNT_W'(POWER_UP_TIMER_CYCLES + RESET_TIME_CYC);
            end
            if (RESET_SRC.power_on) begin
                dly_cnt = dly_cnt + CNT_W'(POWER_ON_CYC);
            end
        end
    end

    // delay restarts on any new source or wake; osc start-up and pll lock timers restart on cold sources only
    assign dly_load  = any_src || WAKE;
    assign ost_load  = cold;
    assign lock_load = cold;
    assign mon_load  = (st_ff.state == ST_DELAY) && dly_done;

    // ------------------------------------------------------------------
    // timers
    // ------------------------------------------------------------------
    rdcs_timer u_dly (
        .clk   (CLK),
        .rstn  (RSTN),
        .load  (dly_load),
        .count (dly_cnt),
        .tick  (1'b1),
        .done  (dly_done)
    );

    rdcs_timer u_ost (
        .clk   (CLK),
        .rstn  (RSTN),
        .load  (ost_load),
        .count (CNT_W'(OSC_STARTUP_PERIODS)),
        .tick  (OSC_TICK),
        .done  (ost_done)
    );

    rdcs_timer u_lock (
        .clk   (CLK),
        .rstn  (RSTN),
        .load  (lock_load),
        .count (CNT_W'(PLL_LOCK_CYC)),
        .tick  (1'b1),
        .done  (lock_done)
    );

    rdcs_timer u_mon (
        .clk   (CLK),
        .rstn  (RSTN),
        .load  (mon_load),
        .count (st_ff.long_path ? CNT_W'(MONITOR_CYCLES) : '0),
        .tick  (1'b1),
        .done  (mon_done)
    );

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.rdata = 16'h0000;
        nxt_st.clk_done = st_ff.clk_done
                        || ((!is_xtal || ost_done) && (!is_pll || (lock_done && PLL_LOCKED)));
        case (st_ff.state)
            ST_HOLD: begin
                nxt_st.sys_rst = 1'b1;
                nxt_st.clk_rel = 1'b0;
                nxt_st.mon     = 1'b0;
                nxt_st.pc      = RESET_PC;
                if (!any_src) begin
                    nxt_st.state = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (dly_done) begin
                    nxt_st.sys_rst = 1'b0;
                    nxt_st.state   = ST_CLKWAIT;
                end
            end
            ST_CLKWAIT: begin
                if (st_ff.clk_done) begin
                    nxt_st.clk_rel = 1'b1;
                    nxt_st.state   = ST_MONWAIT;
                end
            end
            ST_MONWAIT: begin
                if (mon_done) begin
                    nxt_st.mon   = MONITOR_EN;
                    nxt_st.state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (st_ff.mon && !CLOCK_VALID) begin
                    nxt_st.cur_osc = OSC_FAST_RC;
                    nxt_st.fail    = 1'b1;
                end
            end
            default: begin
                nxt_st.state = ST_HOLD;
            end
        endcase

        // a new source or wake restarts the whole sequence
        if (any_src || WAKE) begin
            nxt_st.state   = ST_HOLD;
            nxt_st.sys_rst = 1'b1;
            nxt_st.clk_rel = 1'b0;
            nxt_st.mon     = 1'b0;
            nxt_st.pc      = RESET_PC;
            nxt_st.fail    = 1'b0;
            nxt_st.cur_osc = sel;
            if (cold) begin
                nxt_st.clk_done  = 1'b0;
                nxt_st.long_path = is_xtal || is_pll;
            end else begin
                nxt_st.long_path = 1'b0;
            end
        end

        // software writes first, reset events win
        if (BUS.wr) begin
            if (BUS.addr == ADDR_RESET_CTRL) begin
                nxt_st.reset_ctrl = BUS.wdata;
            end
            if (BUS.addr == ADDR_STATUS && BUS.wdata[OSC_FAIL_BIT]) begin
                nxt_st.fail = 1'b0;
            end
        end
        if (RESET_SRC.power_on) begin
            nxt_st.reset_ctrl = RESET_CTRL_RST;
        end else begin
            if (RESET_SRC.brown_out) begin
                nxt_st.reset_ctrl[RF_BROWN_OUT] = 1'b1;
            end
            if (RESET_SRC.master_clr) begin
                nxt_st.reset_ctrl[RF_MASTER_CLR] = 1'b1;
            end
            if (RESET_SRC.watchdog) begin
                nxt_st.reset_ctrl[RF_WATCHDOG] = 1'b1;
            end
            if (RESET_SRC.software) begin
                nxt_st.reset_ctrl[RF_SOFTWARE] = 1'b1;
            end
            if (RESET_SRC.illegal) begin
                nxt_st.reset_ctrl[RF_ILLEGAL] = 1'b1;
            end
            if (RESET_SRC.trap_conf) begin
                nxt_st.reset_ctrl[RF_TRAP_CONF] = 1'b1;
            end
        end
        if (st_ff.state == ST_RUN && st_ff.mon && !CLOCK_VALID) begin
            nxt_st.fail = 1'b1;
        end

        if (BUS.rd) begin
            case (BUS.addr)
                ADDR_RESET_CTRL: nxt_st.rdata = st_ff.reset_ctrl;
                ADDR_OSC_CTRL:   nxt_st.rdata = 16'(st_ff.cur_osc) << OSC_CUR_LSB;
                ADDR_STATUS:     nxt_st.rdata = {11'h000, st_ff.fail, st_ff.mon,
                                                 st_ff.clk_rel, st_ff.sys_rst, warm};
                ADDR_CONFIG:     nxt_st.rdata = {10'h000, SWITCH_EN, MONITOR_EN,
                                                 REGULATOR_EN, INITIAL_OSC_SELECT_BITS};
                default:         nxt_st.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_ff            <= '0;
            st_ff.state      <= ST_HOLD;
            st_ff.reset_ctrl <= RESET_CTRL_RST;
            st_ff.sys_rst    <= 1'b1;
            st_ff.pc         <= RESET_PC;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign RDATA            = st_ff.rdata;
    assign SYSTEM_RESET_OUT = st_ff.sys_rst;
    assign CLOCK_RELEASE    = st_ff.clk_rel;
    assign MONITOR_START    = st_ff.mon;
    assign OSC_FAIL_TRAP    = st_ff.fail;
    assign CLOCK_SELECT     = st_ff.cur_osc;
    assign PC_RESET         = st_ff.pc;
endmodule : rdcs_sequencer

/* verification/rdcs_monitor.sv */
`timescale 1ns/1ps
module rdcs_monitor
    import rdcs_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RSTN,
    input wire rdcs_src_s   RESET_SRC,
    input wire logic        WAKE,
    input wire logic        MONITOR_EN,
    input wire rdcs_bus_s   BUS,
    input wire logic [15:0] RDATA,
    input wire logic        SYSTEM_RESET_OUT,
    input wire logic        CLOCK_RELEASE,
    input wire logic        MONITOR_START,
    input wire logic        OSC_FAIL_TRAP,
    input wire logic [2:0]  CLOCK_SELECT,
    input wire logic [23:0] PC_RESET
);
    // ----
    // helpers
    // ----
    wire        any_src = |RESET_SRC;
    wire        rd_req  = BUS.rd;
    logic [15:0] hi_cnt_ff;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            hi_cnt_ff <= 16'h0000;
        end else if (!SYSTEM_RESET_OUT) begin
            hi_cnt_ff <= 16'h0000;
        end else if (hi_cnt_ff != 16'hFFFF) begin
            hi_cnt_ff <= hi_cnt_ff + 16'h0001;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    sequence s_src_rise; !any_src ##1 any_src; endsequence
    sequence s_src_gone; any_src ##1 !any_src; endsequence
    property p_pc_zero; PC_RESET == RESET_PC; endproperty
    property p_src_act; s_src_rise |-> ##[0:2] SYSTEM_RESET_OUT; endproperty
    property p_hold; s_src_gone |-> SYSTEM_RESET_OUT [*8]; endproperty
    property p_rst_min; $fell(SYSTEM_RESET_OUT) |-> hi_cnt_ff >= 16'(RESET_TIME_CYC); endproperty
    property p_rst_cause;
        $rose(SYSTEM_RESET_OUT) |-> $past(any_src) || $past(any_src, 2) || $past(WAKE)
            || $past(WAKE, 2);
    endproperty
    property p_exec; $rose(CLOCK_RELEASE) |-> !SYSTEM_RESET_OUT; endproperty
    property p_mon; $rose(MONITOR_START) |-> MONITOR_EN && !SYSTEM_RESET_OUT; endproperty
    property p_trap; $rose(OSC_FAIL_TRAP) |-> ##[0:1] CLOCK_SELECT == OSC_FAST_RC; endproperty
    property p_rd_idle; !$past(rd_req) |-> RDATA == 16'h0000; endproperty
    a_pc_zero: assert property (p_pc_zero) else $error("pc not zero");
    a_src_act: assert property (p_src_act) else $error("source without reset");
    a_hold: assert property (p_hold) else $error("reset released early");
    a_rst_min: assert property (p_rst_min) else $error("reset shorter than reset time");
    a_rst_cause: assert property (p_rst_cause) else $error("reset without cause");
    a_exec: assert property (p_exec) else $error("clock released in reset");
    a_mon: assert property (p_mon) else $error("monitor started early");
    a_trap: assert property (p_trap) else $error("trap without fast rc");
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
endmodule : rdcs_monitor
bind rdcs_sequencer rdcs_monitor u_chk (.CLK(CLK), .RSTN(RSTN), .RESET_SRC(RESET_SRC),
    .WAKE(WAKE), .MONITOR_EN(MONITOR_EN), .BUS(BUS), .RDATA(RDATA),
    .SYSTEM_RESET_OUT(SYSTEM_RESET_OUT), .CLOCK_RELEASE(CLOCK_RELEASE),
    .MONITOR_START(MONITOR_START), .OSC_FAIL_TRAP(OSC_FAIL_TRAP),
    .CLOCK_SELECT(CLOCK_SELECT), .PC_RESET(PC_RESET));

/* verification/rdcs_osc_model.sv */
`timescale 1ns/1ps
module rdcs_osc_model (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic fail,
    output logic      osc_tick,
    output logic      pll_locked,
    output logic      clock_valid
);
    // ----
    // free running crystal, pll locks after a while
    // ----
    logic [7:0] lock_cnt_ff;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            osc_tick    <= 1'b0;
            lock_cnt_ff <= 8'h00;
        end else begin
            osc_tick <= !osc_tick;
            if (lock_cnt_ff != 8'hFF) begin
                lock_cnt_ff <= lock_cnt_ff + 8'h01;
            end
        end
    end
    assign pll_locked  = (lock_cnt_ff == 8'hFF);
    assign clock_valid = !fail;
endmodule : rdcs_osc_model

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
    import rdcs_pkg::*;
    localparam int PUT     = 50;
    localparam int RT      = RESET_TIME_CYC;
    localparam int POR_D   = POWER_ON_CYC + STARTUP_CYC + RT;
    localparam int FLAG[7] = '{RF_POWER_ON, RF_BROWN_OUT, RF_MASTER_CLR, RF_WATCHDOG,
                               RF_SOFTWARE, RF_ILLEGAL, RF_TRAP_CONF};
    logic        clk, rstn, wake, reg_en, sw_en, mon_en, fail;
    logic        osc_tick, pll_locked, clock_valid, sys_rst, clk_rel, mon_start, trap;
    rdcs_src_s   src;
    rdcs_bus_s   bus;
    logic [2:0]  init_sel, clk_sel;
    logic [15:0] rdata, rd_val;
    logic [23:0] pc;
    int          num_errors, total_checks, dly;
    int          cyc = 0;
    rdcs_osc_model u_osc (.clk(clk), .rstn(rstn), .fail(fail), .osc_tick(osc_tick),
        .pll_locked(pll_locked), .clock_valid(clock_valid));
    rdcs_sequencer #(.POWER_UP_TIMER_CYCLES(PUT), .MONITOR_CYCLES(30)) dut (.CLK(clk),
        .RSTN(rstn), .RESET_SRC(src), .WAKE(wake), .REGULATOR_EN(reg_en), .SWITCH_EN(sw_en),
        .MONITOR_EN(mon_en), .INITIAL_OSC_SELECT_BITS(init_sel), .OSC_TICK(osc_tick),
        .PLL_LOCKED(pll_locked), .CLOCK_VALID(clock_valid), .BUS(bus), .RDATA(rdata),
        .SYSTEM_RESET_OUT(sys_rst), .CLOCK_RELEASE(clk_rel), .MONITOR_START(mon_start),
        .OSC_FAIL_TRAP(trap), .CLOCK_SELECT(clk_sel), .PC_RESET(pc));
    // ----
    // tasks
    // ----
    task chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task chk_rng(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask : chk_rng
    task bus_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask : bus_wr
    task bus_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1 d = rdata;
    endtask : bus_rd
    task pulse(input int bitn, output int n);
        @(posedge clk);
        src <= rdcs_src_s'(7'h40 >> bitn);
        wake <= (bitn == 7);
        repeat (3) @(posedge clk);
        src <= '0;
        wake <= 1'b0;
        n = 0;
        while (sys_rst !== 1'b0 && n < 70000) begin
            @(posedge clk);
            n++;
        end
    endtask : pulse
    task end_of_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    // ----
    // sequence
    // ----
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 100000) begin
            num_errors++;
            end_of_test();
        end
    end
    initial begin
        {rstn, wake, fail, src, bus} = '0;
        {reg_en, sw_en, mon_en} = 3'h7;
        init_sel = OSC_PRI;
        num_errors = 0;
        total_checks = 0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        bus_rd(ADDR_RESET_CTRL, rd_val); chk(rd_val, RESET_CTRL_RST);
        bus_rd(4'hF, rd_val); chk(rd_val, 24'h0);
        chk(pc, RESET_PC);
        reg_en <= 1'b0;
        pulse(1, dly); chk_rng(dly, PUT + RT, PUT + RT + 5);
        repeat (4) @(posedge clk);
        chk(clk_rel, 1'b1);
        chk(clk_sel, OSC_PRI);
        chk(mon_start, 1'b0);
        repeat (40) @(posedge clk);
        chk(mon_start, 1'b1);
        reg_en <= 1'b1;
        init_sel <= OSC_FAST_RC;
        for (int i = 2; i < 7; i++) begin
            bus_wr(ADDR_RESET_CTRL, 16'h0000);
            pulse(i, dly); chk_rng(dly, RT, RT + 5);
            bus_rd(ADDR_RESET_CTRL, rd_val); chk(rd_val, 16'h0001 << FLAG[i]);
            chk(clk_sel, OSC_PRI);
        end
        sw_en <= 1'b0;
        pulse(3, dly);
        repeat (4) @(posedge clk);
        chk(clk_sel, OSC_FAST_RC);
        sw_en <= 1'b1;
        @(posedge clk);
        src <= rdcs_src_s'(7'h10);
        repeat (3) @(posedge clk);
        src <= '0;
        repeat (2000) @(posedge clk);
        pulse(4, dly); chk_rng(dly, RT, RT + 5);
        pulse(7, dly); chk_rng(dly, STARTUP_CYC + RT, STARTUP_CYC + RT + 5);
        for (int s = 0; s < 4; s++) begin
            init_sel <= 3'(s);
            pulse(0, dly); chk_rng(dly, POR_D, POR_D + 5);
            repeat (5) @(posedge clk);
            chk(clk_rel, 1'b1);
            chk(clk_sel, 3'(s));
            chk(mon_start, s == 0);
            repeat (40) @(posedge clk);
            chk(mon_start, 1'b1);
        end
        bus_rd(ADDR_RESET_CTRL, rd_val); chk(rd_val, RESET_CTRL_RST);
        bus_rd(ADDR_OSC_CTRL, rd_val); chk(rd_val, {1'b0, OSC_PRI_PLL, 12'h000});
        fail <= 1'b1;
        repeat (10) @(posedge clk);
        chk(trap, 1'b1);
        chk(clk_sel, OSC_FAST_RC);
        fail <= 1'b0;
        bus_wr(ADDR_STATUS, 16'h0008);
        repeat (2) @(posedge clk);
        chk(trap, 1'b0);
        end_of_test();
    end
endmodule : tb
